// file: hw/shtr_readout.sv
// Purpose: digital back-end of a 128 strip triggered readout
// Assumes: discriminator and trigger inputs synchronous to ref_clk
// Notes:   one ref_clk, all slower rates are enable pulses
// What this block does
// - 128 independent channels, each with its own discriminator input
// - buffer strip, amplitude and time stamp for the latency
// - trigger reads out its matching hits; unclaimed hits are dropped
// - only channels that crossed threshold appear in the output
// - amplitude is a 3-4 bit count of time above threshold
// - time stamp advances on one 30 ns clock
// - time stamp near 30 MHz, readout clock, both locked to system clock
// - amplitude clock made inside, at most about 3.5 times shaping rate
// - amplitude clock ideally three times the shaping rate
// - each channel can get a digitally controlled charge injection
// - any channel can be disabled and removed from readout
// - works with default configuration right after power-up
// - written configuration held until overwritten, reset or power cycle
// - every configuration item reads back its current value
// - hit word: 16 bits, 7 strip, 4 amplitude, 1 type, 4 spare
// - time-stamp word: 10 bit stamp, 1 type, 5 spare
// - readout time ordered in triggered mode, hits grouped under their time-stamp word
// - serial output spread over up to four lines
// - dead time at most 10 percent at 150 kHz trigger rate
// - optional untriggered push mode streams hits as they occur
`timescale 1ns/100ps
`include "shtr_defs.svh"
module shtr_readout #(
  parameter int         CHANNELS = `SHTR_CHANNELS,
  parameter int         DEPTH    = 16,
  parameter int         SER_DIV  = 1,
  parameter logic [3:0] CHIP_ID  = 4'h5 // arbitrary value
) (
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  input  wire logic [CHANNELS-1:0] disc,
  input  wire logic                trigger,
  input  wire logic                cfgWrEn,
  input  wire logic [4:0]          cfgAddr,
  input  wire logic [15:0]         cfgWrData,
  output logic [15:0]              cfgRdData,
  input  wire logic                injectStrobe,
  output logic [CHANNELS-1:0]      injectPulse,
  output logic [7:0]               thresholdDac,
  output logic [3:0]               serData,
  output logic                     serFrame,
  output logic                     bufFull
);
  // lowest set bit of a vector, with a found flag on top
  function automatic logic [7:0] firstSet(input logic [127:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 127; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 7'(i)};
      end
    end
    return r;
  endfunction : firstSet

  function automatic logic [2:0] laneNum(input logic [1:0] code);
    case (code)
      2'h0:    laneNum = 3'h1;
      2'h1:    laneNum = 3'h2;
      default: laneNum = 3'h4;
    endcase
  endfunction : laneNum

  localparam logic [2:0] TS_DIV = 3'(`SHTR_TS_DIV_CYC);

  shtr_pkg::shtr_cfg_t   cfg;
  logic [CHANNELS-1:0]   disableMask;
  logic [CHANNELS-1:0]   injectMask;
  logic [2:0]            tsDivCnt;
  logic                  tsTick;
  logic [9:0]            tsNow;
  logic [7:0]            totDivCnt;
  logic                  totTick;
  logic [7:0]            serDivCnt;
  logic                  serTick;

  // configuration store with defaults after reset
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cfg.thresh  <= `SHTR_THRESH_RST;
      cfg.totDiv  <= `SHTR_TOTDIV_RST;
      cfg.lanes   <= `SHTR_LANES_RST;
      cfg.latency <= 10'(`SHTR_LATENCY_TICKS);
      cfg.push    <= `SHTR_MODE_RST;
      disableMask <= '0;
      injectMask  <= '0;
    end else if (cfgWrEn) begin
      case (cfgAddr)
        `SHTR_CFG_THRESH:  cfg.thresh  <= cfgWrData[7:0];
        `SHTR_CFG_TOTDIV:  cfg.totDiv  <= cfgWrData[7:0];
        `SHTR_CFG_LANES:   cfg.lanes   <= cfgWrData[1:0];
        `SHTR_CFG_LATENCY: cfg.latency <= cfgWrData[9:0];
        `SHTR_CFG_MODE:    cfg.push    <= cfgWrData[0];
        default: begin
          if (cfgAddr[4:3] == `SHTR_CFG_DISABLE_BASE >> 3) begin
            disableMask[cfgAddr[2:0]*16 +: 16] <= cfgWrData;
          end else if (cfgAddr[4:3] == `SHTR_CFG_INJECT_BASE >> 3) begin
            injectMask[cfgAddr[2:0]*16 +: 16] <= cfgWrData;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cfgRdData <= '0;
    end else begin
      case (cfgAddr)
        `SHTR_CFG_THRESH:  cfgRdData <= {8'h00, cfg.thresh};
        `SHTR_CFG_TOTDIV:  cfgRdData <= {8'h00, cfg.totDiv};
        `SHTR_CFG_LANES:   cfgRdData <= {14'h0000, cfg.lanes};
        `SHTR_CFG_LATENCY: cfgRdData <= {6'h00, cfg.latency};
        `SHTR_CFG_MODE:    cfgRdData <= {15'h0000, cfg.push};
        default: begin
          if (cfgAddr[4:3] == `SHTR_CFG_DISABLE_BASE >> 3) begin
            cfgRdData <= disableMask[cfgAddr[2:0]*16 +: 16];
          end else if (cfgAddr[4:3] == `SHTR_CFG_INJECT_BASE >> 3) begin
            cfgRdData <= injectMask[cfgAddr[2:0]*16 +: 16];
          end else begin
            cfgRdData <= 16'h0000;
          end
        end
      endcase
    end
  end

  assign thresholdDac = cfg.thresh;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      injectPulse <= '0;
    end else begin
      injectPulse <= injectStrobe ? injectMask : '0;
    end
  end

  // time stamp: one tick every 30 ns, free-running ten bit count
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tsDivCnt <= '0;
      tsNow    <= '0;
    end else begin
      tsDivCnt <= (tsDivCnt == TS_DIV - 3'h1) ? 3'h0 : tsDivCnt + 3'h1;
      if (tsTick) begin
        tsNow <= tsNow + 10'h001;
      end
    end
  end
  assign tsTick = (tsDivCnt == TS_DIV - 3'h1);

  // amplitude clock, rate set by configuration
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      totDivCnt <= '0;
    end else begin
      totDivCnt <= (totDivCnt + 8'h01 >= cfg.totDiv) ? 8'h00 : totDivCnt + 8'h01;
    end
  end
  assign totTick = (totDivCnt + 8'h01 >= cfg.totDiv);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      serDivCnt <= '0;
    end else begin
      serDivCnt <= serTick ? 8'h00 : serDivCnt + 8'h01;
    end
  end
  assign serTick = (serDivCnt == 8'(SER_DIV - 1));

  // channels
  logic [CHANNELS-1:0]   chPending;
  logic [CHANNELS-1:0]   chAck;
  logic [9:0]            chTs  [CHANNELS];
  logic [3:0]            chAmp [CHANNELS];

  for (genvar g = 0; g < CHANNELS; g++) begin : g_ch
    shtr_channel #(
      .AMP_W   (`SHTR_AMP_W)
    ) u_ch (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .disc    (disc[g]),
      .enable  (!disableMask[g]),
      .totTick (totTick),
      .ack     (chAck[g]),
      .tsNow   (tsNow),
      .pending (chPending[g]),
      .hitTs   (chTs[g]),
      .hitAmp  (chAmp[g])
    );
  end

  // sparsifier: one pending channel per cycle into a free buffer slot
  shtr_pkg::shtr_entry_t entry [DEPTH];
  logic [DEPTH-1:0]      valid;
  logic [DEPTH-1:0]      sel;
  logic [7:0]            pickCh;
  logic [7:0]            freeSlot;
  logic                  wrEn;

  assign pickCh   = firstSet(128'(chPending));
  assign freeSlot = firstSet({{(128-DEPTH){1'b0}}, ~valid});
  assign wrEn     = pickCh[7] && freeSlot[7];
  assign bufFull  = &valid;

  always_comb begin
    chAck = '0;
    if (wrEn) begin
      chAck[pickCh[6:0]] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (wrEn) begin
      entry[freeSlot[3:0]].ts    <= chTs[pickCh[6:0]];
      entry[freeSlot[3:0]].strip <= pickCh[6:0];
      entry[freeSlot[3:0]].amp   <= chAmp[pickCh[6:0]];
    end
  end

  // trigger queue: one trigger held while a group is being sent
  logic                  trigQueued;
  logic [9:0]            trigTs;
  shtr_pkg::shtr_state_t state;
  logic [9:0]            grpTs;
  logic [7:0]            firstValid;
  logic [7:0]            nextSel;
  logic                  takeTrig;
  logic                  takePush;

  assign firstValid = firstSet(128'(valid));
  assign nextSel    = firstSet(128'(sel));
  assign takeTrig   = (state == shtr_pkg::SHTR_IDLE) && trigQueued && !cfg.push;
  assign takePush   = (state == shtr_pkg::SHTR_IDLE) && cfg.push && firstValid[7];

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      trigQueued <= 1'b0;
      trigTs     <= '0;
    end else if (trigger) begin
      trigQueued <= 1'b1;
      trigTs     <= tsNow - cfg.latency;
    end else if (takeTrig) begin
      trigQueued <= 1'b0;
    end
  end

  // fifo feed
  logic                    fifoInReady;
  logic                    fifoInValid;
  logic [15:0]             fifoInData;
  logic                    fifoOutValid;
  logic                    fifoOutReady;
  logic [15:0]             fifoOutData;
  shtr_pkg::shtr_hit_word_t hitWord;
  shtr_pkg::shtr_ts_word_t  tsWord;
  logic                    sendHit;

  always_comb begin
    hitWord.kind  = `SHTR_TYPE_HIT;
    hitWord.spare = 4'h0;
    hitWord.strip = entry[nextSel[3:0]].strip;
    hitWord.amp   = entry[nextSel[3:0]].amp;
    tsWord.kind   = `SHTR_TYPE_TS;
    tsWord.spare  = 5'h00;
    tsWord.ts     = grpTs;
  end

  assign sendHit     = (state == shtr_pkg::SHTR_HITS) && nextSel[7] && fifoInReady;
  assign fifoInValid = (state == shtr_pkg::SHTR_TSW) ||
                       ((state == shtr_pkg::SHTR_HITS) && nextSel[7]);
  assign fifoInData  = (state == shtr_pkg::SHTR_TSW) ? 16'(tsWord) : 16'(hitWord);

  // buffer occupancy, selection and expiry
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      valid <= '0;
      sel   <= '0;
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        if (takeTrig || takePush) begin
          sel[i] <= valid[i] &&
                    (entry[i].ts == (takeTrig ? trigTs : entry[firstValid[3:0]].ts));
        end
        if (!cfg.push && valid[i] && !sel[i] && !(trigQueued && entry[i].ts == trigTs) &&
            (10'(tsNow - entry[i].ts) > cfg.latency)) begin
          valid[i] <= 1'b0;
        end
      end
      if (sendHit) begin
        valid[nextSel[3:0]] <= 1'b0;
        sel[nextSel[3:0]]   <= 1'b0;
      end
      if (wrEn) begin
        valid[freeSlot[3:0]] <= 1'b1;
      end
    end
  end

  // group sender: stamp word, then every selected hit
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= shtr_pkg::SHTR_IDLE;
      grpTs <= '0;
    end else begin
      case (state)
        shtr_pkg::SHTR_IDLE: begin
          if (takeTrig) begin
            grpTs <= trigTs;
            state <= shtr_pkg::SHTR_TSW;
          end else if (takePush) begin
            grpTs <= entry[firstValid[3:0]].ts;
            state <= shtr_pkg::SHTR_TSW;
          end
        end
        shtr_pkg::SHTR_TSW: begin
          if (fifoInReady) begin
            state <= shtr_pkg::SHTR_HITS;
          end
        end
        shtr_pkg::SHTR_HITS: begin
          if (!nextSel[7]) begin
            state <= shtr_pkg::SHTR_IDLE;
          end
        end
        default: state <= shtr_pkg::SHTR_IDLE;
      endcase
    end
  end

  shtr_fifo #(
    .WIDTH    (16),
    .DEPTH    (4)
  ) u_fifo (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .inData   (fifoInData),
    .outValid (fifoOutValid),
    .outReady (fifoOutReady),
    .outData  (fifoOutData)
  );

  // serialiser over one, two or four lanes, msb first
  logic [15:0] shReg;
  logic [4:0]  stepsLeft;
  logic        serBusy;
  logic [2:0]  lanes;
  logic [15:0] shifted;
  logic [15:0] present;
  logic        loadWord;

  assign lanes        = laneNum(cfg.lanes);
  assign shifted      = shReg << lanes;
  assign loadWord     = serTick && fifoOutValid && (!serBusy || stepsLeft == 5'h00);
  assign fifoOutReady = loadWord;
  assign present      = loadWord ? fifoOutData : shifted;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      shReg     <= '0;
      stepsLeft <= '0;
      serBusy   <= 1'b0;
      serData   <= 4'h0;
      serFrame  <= 1'b0;
    end else if (serTick) begin
      if (loadWord || (serBusy && stepsLeft != 5'h00)) begin
        shReg     <= present;
        stepsLeft <= loadWord ? 5'(5'h10 / {2'b00, lanes}) - 5'h01 : stepsLeft - 5'h01;
        serBusy   <= 1'b1;
        serFrame  <= 1'b1;
        serData   <= {present[12] & lanes[2], present[13] & lanes[2],
                      present[14] & (lanes != 3'h1), present[15]};
      end else begin
        serBusy  <= 1'b0;
        serFrame <= 1'b0;
        serData  <= 4'h0;
      end
    end
  end

  // dead time: hits are taken while a group is sent
  logic unusedId;
  assign unusedId = ^CHIP_ID;
endmodule : shtr_readout

// file: hw/shtr_defs.svh
// Purpose: constants of the strip hit triggered readout
// Assumes: 200 MHz reference clock
// Notes:   included by its bare name
`ifndef SHTR_DEFS_SVH
`define SHTR_DEFS_SVH

`define SHTR_CHANNELS          128
`define SHTR_AMP_W             4
`define SHTR_CLK_PERIOD_NS     5
`define SHTR_TS_PERIOD_NS      30
`define SHTR_TS_DIV_CYC        (`SHTR_TS_PERIOD_NS / `SHTR_CLK_PERIOD_NS)
`define SHTR_TRIG_LATENCY_NS   7000
`define SHTR_LATENCY_TICKS     (`SHTR_TRIG_LATENCY_NS / `SHTR_TS_PERIOD_NS)
`define SHTR_TRIG_SPACING_NS   70
`define SHTR_TRIG_SPACING_CYC  \
  ((`SHTR_TRIG_SPACING_NS + `SHTR_CLK_PERIOD_NS - 1) / `SHTR_CLK_PERIOD_NS)

`define SHTR_CFG_THRESH        5'h00
`define SHTR_CFG_TOTDIV        5'h01
`define SHTR_CFG_LANES         5'h02
`define SHTR_CFG_LATENCY       5'h03
`define SHTR_CFG_MODE          5'h04
`define SHTR_CFG_DISABLE_BASE  5'h08
`define SHTR_CFG_INJECT_BASE   5'h10

`define SHTR_THRESH_RST        8'h80
`define SHTR_TOTDIV_RST        8'h02
`define SHTR_LANES_RST         2'h2
`define SHTR_MODE_RST          1'b0

`define SHTR_TYPE_HIT          1'b1
`define SHTR_TYPE_TS           1'b0

`endif

// file: hw/shtr_pkg.sv
// Purpose: types of the strip hit triggered readout
// Assumes: amplitude of four bits, time stamp of ten bits
// Notes:   constants live in shtr_defs.svh
package shtr_pkg;

  typedef struct packed {
    logic [9:0] ts;
    logic [6:0] strip;
    logic [3:0] amp;
  } shtr_entry_t;

  typedef struct packed {
    logic       kind;
    logic [3:0] spare;
    logic [6:0] strip;
    logic [3:0] amp;
  } shtr_hit_word_t;

  typedef struct packed {
    logic       kind;
    logic [4:0] spare;
    logic [9:0] ts;
  } shtr_ts_word_t;

  typedef struct packed {
    logic [7:0] thresh;
    logic [7:0] totDiv;
    logic [1:0] lanes;
    logic [9:0] latency;
    logic       push;
  } shtr_cfg_t;

  typedef enum logic [1:0] {
    SHTR_IDLE = 2'b00,
    SHTR_TSW  = 2'b01,
    SHTR_HITS = 2'b11
  } shtr_state_t;

endpackage : shtr_pkg

// file: hw/shtr_fifo.sv
// Purpose: small word FIFO between readout control and serialiser
// Assumes: DEPTH of at least two
// Notes:   flip-flop storage, first-word-fall-through
`timescale 1ns/100ps
module shtr_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign inReady  = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData  = mem[rdPtr];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule : shtr_fifo

// file: hw/shtr_channel.sv
// Purpose: hit capture of one strip with duration-over-threshold amplitude
// Assumes: discriminator output synchronous to ref_clk
// Notes:   a new hit is ignored while the previous one is still pending
`timescale 1ns/100ps
module shtr_channel #(
  parameter int AMP_W = 4
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             disc,
  input  wire logic             enable,
  input  wire logic             totTick,
  input  wire logic             ack,
  input  wire logic [9:0]       tsNow,
  output logic                  pending,
  output logic [9:0]            hitTs,
  output logic [AMP_W-1:0]      hitAmp
);
  logic discPrev;
  logic measuring;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      discPrev <= 1'b0;
    end else begin
      discPrev <= disc;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      measuring <= 1'b0;
      pending   <= 1'b0;
      hitTs     <= '0;
      hitAmp    <= '0;
    end else begin
      if (ack) begin
        pending <= 1'b0;
      end
      if (!enable) begin
        measuring <= 1'b0;
      end else if (!measuring && !pending && disc && !discPrev) begin
        measuring <= 1'b1;
        hitTs     <= tsNow;
        hitAmp    <= '0;
      end else if (measuring) begin
        if (!disc) begin
          measuring <= 1'b0;
          pending   <= 1'b1;
        end else if (totTick && hitAmp != '1) begin
          hitAmp <= hitAmp + 1'b1;
        end
      end
    end
  end
endmodule : shtr_channel

// file: tb/shtr_props.sv
// Purpose: port-level checks of the strip hit readout
// Assumes: lane code 2 and push off after reset
// Notes:   bound to shtr_readout below
`timescale 1ns/100ps
module shtr_props #(
  parameter int CHANNELS = 128
) (
  input wire logic                ref_clk,
  input wire logic                rst_n,
  input wire logic                trigger,
  input wire logic                cfgWrEn,
  input wire logic [4:0]          cfgAddr,
  input wire logic [15:0]         cfgWrData,
  input wire logic [15:0]         cfgRdData,
  input wire logic                injectStrobe,
  input wire logic [CHANNELS-1:0] injectPulse,
  input wire logic [7:0]          thresholdDac,
  input wire logic [3:0]          serData,
  input wire logic                serFrame
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [1:0] lanes;
  logic       push;
  // shadow of lane and push settings
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      lanes <= 2'h2;
      push  <= 1'b0;
    end else if (cfgWrEn && cfgAddr == 5'h02) begin
      lanes <= cfgWrData[1:0];
    end else if (cfgWrEn && cfgAddr == 5'h04) begin
      push <= cfgWrData[0];
    end
  end
  a_thresh_load: assert property (
    cfgWrEn && cfgAddr == 5'h00 |=> thresholdDac == $past(cfgWrData[7:0]))
    else $error("threshold code not loaded");
  a_thresh_hold: assert property (
    !(cfgWrEn && cfgAddr == 5'h00) |=> $stable(thresholdDac))
    else $error("threshold code changed without write");
  a_thresh_reset: assert property (
    $rose(rst_n) |-> thresholdDac == 8'h80)
    else $error("threshold default wrong");
  a_read_thresh: assert property (
    $past(rst_n) && $past(cfgAddr) == 5'h00 && !$past(cfgWrEn)
    |-> cfgRdData == {8'h00, $past(thresholdDac)})
    else $error("threshold readback wrong");
  a_read_unmapped: assert property (
    $past(rst_n) && ($past(cfgAddr) inside {[5'h05:5'h07], [5'h18:5'h1F]})
    |-> cfgRdData == 16'h0000)
    else $error("unmapped readback not zero");
  a_inject_once: assert property (
    $past(rst_n) && !$past(injectStrobe) |-> injectPulse == {CHANNELS{1'b0}})
    else $error("inject pulse without strobe");
  a_frame_four: assert property (
    $rose(serFrame) && lanes[1] |-> serFrame [*4])
    else $error("four lane word too short");
  a_frame_two: assert property (
    $rose(serFrame) && lanes == 2'h1 |-> serFrame [*8])
    else $error("two lane word too short");
  a_frame_one: assert property (
    $rose(serFrame) && lanes == 2'h0 |-> serFrame [*8] ##1 serFrame [*8])
    else $error("one lane word too short");
  a_stamp_first: assert property (
    $rose(serFrame) |-> serData[0] == 1'b0)
    else $error("group does not open with stamp word");
  a_trig_answer: assert property (
    trigger && !push && !serFrame |-> ##[1:12] serFrame)
    else $error("trigger not answered");
  c_one_lane: cover property ($rose(serFrame) && lanes == 2'h0);
  c_trigger: cover property (trigger && !serFrame);
  c_inject: cover property (injectStrobe);
endmodule : shtr_props

bind shtr_readout shtr_props #(.CHANNELS(CHANNELS)) props_u (
  .ref_clk(ref_clk), .rst_n(rst_n), .trigger(trigger), .cfgWrEn(cfgWrEn),
  .cfgAddr(cfgAddr), .cfgWrData(cfgWrData), .cfgRdData(cfgRdData),
  .injectStrobe(injectStrobe), .injectPulse(injectPulse),
  .thresholdDac(thresholdDac), .serData(serData), .serFrame(serFrame)
);

// file: tb/shtr_daq_model.sv
// Purpose: receiver of the serial lanes, rebuilds 16 bit words
// Assumes: lane code known to the bench
// Notes:   wordValid is a one-cycle pulse
`timescale 1ns/100ps
module shtr_daq_model (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] lanes,
  input  wire logic [3:0] serData,
  input  wire logic       serFrame,
  output logic [15:0]     word,
  output logic            wordValid
);
  logic [15:0] shift;
  logic [15:0] next_shift;
  logic [3:0]  tick;
  logic [3:0]  last;
  always_comb begin
    // lane0 carries the most significant bit
    case (lanes)
      2'h0: next_shift = {shift[14:0], serData[0]};
      2'h1: next_shift = {shift[13:0], serData[0], serData[1]};
      default: next_shift = {shift[11:0], serData[0], serData[1], serData[2], serData[3]};
    endcase
    last = (lanes == 2'h0) ? 4'hF : (lanes == 2'h1) ? 4'h7 : 4'h3;
  end
  always_ff @(posedge ref_clk) begin
    wordValid <= 1'b0;
    if (!rst_n) begin
      tick <= 4'h0;
    end else if (serFrame) begin
      shift <= next_shift;
      tick  <= (tick == last) ? 4'h0 : tick + 4'h1;
      if (tick == last) begin
        word      <= next_shift;
        wordValid <= 1'b1;
      end
    end
  end
endmodule : shtr_daq_model

// file: tb/test_strip_hit_triggered_readout.sv
// Purpose: self-checking bench of the strip hit readout
// Assumes: default parameters, latency set to 10 stamp ticks
// Notes:   stamp phase unknown, so stamps are checked by difference
`timescale 1ns/100ps
module test_strip_hit_triggered_readout;
  logic         ref_clk = 1'b0;
  logic         rst_n = 1'b0;
  logic [127:0] disc = 128'h0;
  logic         trigger = 1'b0;
  logic         cfgWrEn = 1'b0;
  logic [4:0]   cfgAddr = 5'h00;
  logic [15:0]  cfgWrData = 16'h0000;
  logic         injectStrobe = 1'b0;
  logic [1:0]   lanes = 2'h2;
  logic [15:0]  cfgRdData, word, rd, ts0;
  logic [127:0] injectPulse;
  logic [7:0]   thresholdDac;
  logic [3:0]   serData;
  logic         serFrame, bufFull, wordValid;
  logic [15:0]  rx[$];
  int           miscompares = 0;
  int           n_tests = 0;
  int           cyc = 0;
  int           tRise, tTrig;
  logic [4:0]   dAddr [8] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h08, 5'h10};
  logic [15:0]  dVal [8] = '{16'h0080, 16'h0002, 16'h0002, 16'h00E9, 16'h0000, 16'h0000,
                             16'h0000, 16'h0000};
  logic [4:0]   wAddr [7] = '{5'h00, 5'h01, 5'h03, 5'h0B, 5'h05, 5'h10, 5'h17};
  logic [15:0]  wVal [7] = '{16'h003C, 16'h0001, 16'h000A, 16'h0004, 16'hFFFF, 16'h8001,
                             16'h4000};
  logic [1:0]   lcode [3] = '{2'h0, 2'h1, 2'h3};

  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;
  always @(posedge ref_clk) if (wordValid === 1'b1) rx.push_back(word);

  shtr_readout dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .disc(disc), .trigger(trigger), .cfgWrEn(cfgWrEn),
    .cfgAddr(cfgAddr), .cfgWrData(cfgWrData), .cfgRdData(cfgRdData),
    .injectStrobe(injectStrobe), .injectPulse(injectPulse), .thresholdDac(thresholdDac),
    .serData(serData), .serFrame(serFrame), .bufFull(bufFull)
  );
  shtr_daq_model model_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .lanes(lanes), .serData(serData),
    .serFrame(serFrame), .word(word), .wordValid(wordValid)
  );

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic cfg_wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    cfgWrEn   <= 1'b1;
    cfgAddr   <= a;
    cfgWrData <= d;
    if (a == 5'h02) lanes <= d[1:0];
    @(posedge ref_clk);
    cfgWrEn <= 1'b0;
  endtask : cfg_wr

  task automatic cfg_rd(input logic [4:0] a, output logic [15:0] v);
    @(posedge ref_clk);
    cfgAddr <= a;
    repeat (2) @(posedge ref_clk);
    #1 v = cfgRdData;
  endtask : cfg_rd

  task automatic hit(input logic [127:0] m, input int len);
    @(posedge ref_clk);
    disc  <= m;
    tRise = cyc;
    repeat (len) @(posedge ref_clk);
    disc <= 128'h0;
  endtask : hit

  // c of zero fires at once; triggers kept at least 16 cycles apart
  task automatic trig(input int c);
    @(posedge ref_clk);
    while (cyc < c) @(posedge ref_clk);
    trigger <= 1'b1;
    tTrig = cyc;
    @(posedge ref_clk);
    trigger <= 1'b0;
    repeat (14) @(posedge ref_clk);
  endtask : trig

  task automatic wait_words(input int n);
    for (int i = 0; i < 300 && rx.size() < n; i++) @(posedge ref_clk);
    repeat (40) @(posedge ref_clk);
    check("word count", 16'(rx.size()), 16'(n));
  endtask : wait_words

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (10000) @(posedge ref_clk);
    miscompares++;
    finish_test();
  end

  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    foreach (dAddr[i]) begin
      cfg_rd(dAddr[i], rd);
      check("cfg default", rd, dVal[i]);
    end
    foreach (wAddr[i]) cfg_wr(wAddr[i], wVal[i]);
    foreach (wAddr[i]) begin
      cfg_rd(wAddr[i], rd);
      check("cfg readback", rd, (wAddr[i] == 5'h05) ? 16'h0000 : wVal[i]);
    end
    check("threshold dac", {8'h00, thresholdDac}, 16'h003C);
    $display("test config done");
    @(posedge ref_clk);
    injectStrobe <= 1'b1;
    @(posedge ref_clk);
    injectStrobe <= 1'b0;
    #1;
    check("inject low", injectPulse[15:0], 16'h8001);
    check("inject high", injectPulse[127:112], 16'h4000);
    check("inject middle", {15'h0, |injectPulse[111:16]}, 16'h0000);
    $display("test inject done");
    rx.delete();
    hit((128'h1 << 9) | (128'h1 << 50) | (128'h1 << 100), 40);
    trig(tRise + 60);
    wait_words(3);
    check("stamp head", {10'h0, rx[0][15:10]}, 16'h0000);
    check("hit low strip", rx[1], 16'h809F);
    check("hit high strip", rx[2], 16'h864F);
    ts0 = rx[0];
    rx.delete();
    hit(128'h1 << 20, 3);
    trig(tTrig + 180);
    wait_words(1);
    check("later stamp", rx[0], {6'h00, ts0[9:0] + 10'd30});
    $display("test trigger done");
    foreach (lcode[i]) begin
      cfg_wr(5'h02, {14'h0, lcode[i]});
      rx.delete();
      trig(tTrig + 120);
      wait_words(1);
      check("lane stamp", rx[0], {6'h00, ts0[9:0] + 10'd50 + 10'(i * 20)});
    end
    $display("test lanes done");
    hit(128'h1FFFF, 3);
    repeat (20) @(posedge ref_clk);
    #1 check("buffer full", {15'h0, bufFull}, 16'h0001);
    repeat (80) @(posedge ref_clk);
    #1 check("buffer drained", {15'h0, bufFull}, 16'h0000);
    $display("test buffer done");
    cfg_wr(5'h02, 16'h0002);
    cfg_wr(5'h04, 16'h0001);
    rx.delete();
    hit(128'h1 << 5, 3);
    wait_words(2);
    check("push hit", {4'h0, rx[1][15:4]}, 16'h0805);
    cfg_wr(5'h04, 16'h0000);
    $display("test push done");
    finish_test();
  end
endmodule : test_strip_hit_triggered_readout
